/* File: design/supervisor_watchdog_reset.sv */
// Supervisor top: reset stretcher, watchdog, power-fail flag, AXI4-Lite
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "svr_defines.svh"

// Behaviour
// - Reset low while supply below threshold
// - Reset held one timeout after conditions end
// - Plain variant: kick edge each timeout else reset
// - Plain variant: edge or reset clears counter
// - Window variant: early or late edge resets
// - Window variant: counting starts after reset release
// - Window variant: valid edge or reset clears
// - Window variant: select straps set ratio; code 01 disables
// - Period strap high selects fixed watchdog timeout
// - Period strap high selects fixed reset timeout
// - Power-fail flag low while sense below threshold
// - Plain variant: disable input low turns watchdog off
// - Reset assertion clears watchdog counter
module supervisor_watchdog_reset #(
  parameter int unsigned CW = 32,
  parameter int unsigned RST_CYC = `SVR_RST_TIME_MS * `SVR_CYC_PER_MS,
  parameter int unsigned WD_CYC = `SVR_WD_TIME_MS * `SVR_CYC_PER_MS
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  // Analog comparator results
  input wire logic SUPPLY_BELOW_THRESH_I,
  input wire logic POWER_FAIL_SENSE_IN_BELOW_I,
  // Watchdog pins and straps
  input wire logic WATCHDOG_KICK_INPUT_I,
  input wire logic WINDOW_SELECT_BIT0_I,
  input wire logic WINDOW_SELECT_BIT1_I,
  input wire logic WATCHDOG_DISABLE_IN_I,
  input wire logic WATCHDOG_PERIOD_STRAP_I,
  input wire logic RESET_PERIOD_STRAP_I,
  // Supervisor outputs
  output logic RESET_N_O,
  output logic POWER_FAIL_FLAG_OUT_N_O,
  output logic IRQ_O,
  // AXI4-Lite write address and data
  input wire logic [5:0] AXI_AWADDR_I,
  input wire logic AXI_AWVALID_I,
  output logic AXI_AWREADY_O,
  input wire logic [31:0] AXI_WDATA_I,
  input wire logic [3:0] AXI_WSTRB_I,
  input wire logic AXI_WVALID_I,
  output logic AXI_WREADY_O,
  // AXI4-Lite write response
  output logic [1:0] AXI_BRESP_O,
  output logic AXI_BVALID_O,
  input wire logic AXI_BREADY_I,
  // AXI4-Lite read
  input wire logic [5:0] AXI_ARADDR_I,
  input wire logic AXI_ARVALID_I,
  output logic AXI_ARREADY_O,
  output logic [31:0] AXI_RDATA_O,
  output logic [1:0] AXI_RRESP_O,
  output logic AXI_RVALID_O,
  input wire logic AXI_RREADY_I
);

  // Timeouts must fit the counters; fast limit must stay above zero
  generate
    if (CW < 24 || CW > 32 || RST_CYC < 1 || WD_CYC < 128 ||
        RST_CYC > (64'h1 << CW) - 1 || WD_CYC > (64'h1 << CW) - 1)
    begin : g_bad_param
      $error("supervisor_watchdog_reset: unsupported parameters");
    end
  endgenerate

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  // Address decode, shared by read and write paths
  function automatic logic [2:0] reg_sel(input logic [5:0] a);
    case (a)
      `SVR_OFS_CTRL: reg_sel = `SVR_SEL_CTRL;
      `SVR_OFS_STATUS: reg_sel = `SVR_SEL_STATUS;
      `SVR_OFS_INT_STAT: reg_sel = `SVR_SEL_INT_STAT;
      `SVR_OFS_INT_MASK: reg_sel = `SVR_SEL_INT_MASK;
      `SVR_OFS_WD_ADJ: reg_sel = `SVR_SEL_WD_ADJ;
      `SVR_OFS_RST_ADJ: reg_sel = `SVR_SEL_RST_ADJ;
      default: reg_sel = `SVR_SEL_NONE;
    endcase
  endfunction : reg_sel

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction : merge

  // Software state
  logic ctrl_ff; // Windowed variant when set
  logic [`SVR_EV_W-1:0] int_stat_ff; // Sticky events
  logic [`SVR_EV_W-1:0] int_mask_ff; // Interrupt enables
  logic [31:0] wd_adj_ff; // Capacitor-set watchdog timeout, cycles
  logic [31:0] rst_adj_ff; // Capacitor-set reset timeout, cycles
  // Bus holding state
  logic aw_full_ff;
  logic w_full_ff;
  logic [5:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic do_write; // Both halves present, response slot free
  logic [31:0] wmerged; // Masked write data for W1C

  // Supervisor state
  svr_pkg::rst_state_t state_ff;
  svr_pkg::rst_state_t nxt_state;
  logic kick_prev_ff; // Kick pin one cycle ago
  logic [CW-1:0] rst_cnt; // Stretch counter
  logic [CW-1:0] wd_cnt; // Watchdog counter
  logic [CW-1:0] rst_len;
  logic [CW-1:0] wd_len;
  logic [CW-1:0] fast_len;
  logic [2:0] ratio_shift;
  logic [1:0] wsel;
  logic windowed;
  logic running;
  logic wd_en;
  logic kick_edge;
  logic wd_late;
  logic wd_early;
  logic wd_fault;
  logic wd_clear;
  logic stretch_done;
  logic [`SVR_EV_W-1:0] events;

  assign windowed = ctrl_ff;
  assign running = (state_ff == svr_pkg::ST_RUN);
  assign wsel = {WINDOW_SELECT_BIT1_I, WINDOW_SELECT_BIT0_I};
  assign kick_edge = WATCHDOG_KICK_INPUT_I ^ kick_prev_ff;

  // Strap high: fixed timeout; low: software stands in for the capacitor
  // fixed reset timeout
  assign rst_len = RESET_PERIOD_STRAP_I ? CW'(RST_CYC) : rst_adj_ff[CW-1:0];
  assign wd_len = WATCHDOG_PERIOD_STRAP_I ? CW'(WD_CYC) : wd_adj_ff[CW-1:0];

  // Window ratio and enable from straps or disable pin
  // ratio select and disable code
  always_comb begin
    case (wsel)
      `SVR_WSEL_R8: ratio_shift = `SVR_SHIFT_R8;
      `SVR_WSEL_R16: ratio_shift = `SVR_SHIFT_R16;
      default: ratio_shift = `SVR_SHIFT_R64;
    endcase
    // disable input applies to the plain variant
    wd_en = windowed ? (wsel != `SVR_WSEL_DIS) : WATCHDOG_DISABLE_IN_I;
  end

  assign fast_len = wd_len >> ratio_shift;

  // Late: counter ran to the slow limit with no edge
  // missing kick times out
  assign wd_late = ({1'b0, wd_cnt} + 1'b1 >= {1'b0, wd_len}) && !kick_edge;
  // early edge in the windowed variant
  assign wd_early = windowed && kick_edge && (wd_cnt < fast_len);
  assign wd_fault = running && wd_en && (wd_late || wd_early);
  // Counter idles at zero until reset is released
  // clear on edge or reset
  assign wd_clear = !running || !wd_en || kick_edge || wd_fault;
  assign stretch_done = ({1'b0, rst_cnt} + 1'b1 >= {1'b0, rst_len});

  // Watchdog counter
  svr_interval_timer #(.CW(CW)) u_wd_timer (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .clear_i(wd_clear),
    .count_o(wd_cnt)
  );

  // Reset stretch counter, runs only while stretching
  svr_interval_timer #(.CW(CW)) u_rst_timer (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .clear_i(state_ff != svr_pkg::ST_STRETCH),
    .count_o(rst_cnt)
  );

  // Reset sequencing; low supply overrides every state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      svr_pkg::ST_HOLD: nxt_state = svr_pkg::ST_STRETCH;
      svr_pkg::ST_STRETCH: begin
        if (stretch_done) begin
          nxt_state = svr_pkg::ST_RUN;
        end
      end
      // watchdog pulse uses the stretch timer
      svr_pkg::ST_RUN: begin
        if (wd_fault) begin
          nxt_state = svr_pkg::ST_STRETCH;
        end
      end
      default: nxt_state = svr_pkg::ST_HOLD;
    endcase
    if (SUPPLY_BELOW_THRESH_I) begin
      nxt_state = svr_pkg::ST_HOLD;
    end
  end

  // State, reset pin and kick history
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      state_ff <= svr_pkg::ST_HOLD;
      RESET_N_O <= 1'b0;
      kick_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      RESET_N_O <= (nxt_state == svr_pkg::ST_RUN);
      kick_prev_ff <= WATCHDOG_KICK_INPUT_I;
    end
  end

  // Power-fail flag follows the comparator, one cycle late
  // flag low while sense below
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      POWER_FAIL_FLAG_OUT_N_O <= 1'b1;
    end else begin
      POWER_FAIL_FLAG_OUT_N_O <= !POWER_FAIL_SENSE_IN_BELOW_I;
    end
  end

  // Event sources for sticky status
  assign events[`SVR_EV_WD_BIT] = wd_fault;
  assign events[`SVR_EV_SUPPLY_BIT] = SUPPLY_BELOW_THRESH_I &&
                                      (state_ff != svr_pkg::ST_HOLD);
  assign events[`SVR_EV_PF_BIT] = POWER_FAIL_SENSE_IN_BELOW_I &&
                                  POWER_FAIL_FLAG_OUT_N_O;

  // Write path: halves taken in any order, one write outstanding
  assign do_write = aw_full_ff && w_full_ff && !AXI_BVALID_O;
  assign wmerged = merge(32'h0, wdata_ff, wstrb_ff);

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      aw_full_ff <= 1'b0;
      AXI_AWREADY_O <= 1'b1;
      awaddr_ff <= '0;
    end else if (AXI_AWVALID_I && AXI_AWREADY_O) begin
      aw_full_ff <= 1'b1;
      AXI_AWREADY_O <= 1'b0;
      awaddr_ff <= AXI_AWADDR_I;
    end else if (do_write) begin
      aw_full_ff <= 1'b0;
    end else if (AXI_BVALID_O && AXI_BREADY_I) begin
      AXI_AWREADY_O <= 1'b1;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      w_full_ff <= 1'b0;
      AXI_WREADY_O <= 1'b1;
      wdata_ff <= '0;
      wstrb_ff <= '0;
    end else if (AXI_WVALID_I && AXI_WREADY_O) begin
      w_full_ff <= 1'b1;
      AXI_WREADY_O <= 1'b0;
      wdata_ff <= AXI_WDATA_I;
      wstrb_ff <= AXI_WSTRB_I;
    end else if (do_write) begin
      w_full_ff <= 1'b0;
    end else if (AXI_BVALID_O && AXI_BREADY_I) begin
      AXI_WREADY_O <= 1'b1;
    end
  end

  // Write response; unmapped or read-only targets answer SLVERR
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      AXI_BVALID_O <= 1'b0;
      AXI_BRESP_O <= `SVR_RESP_OKAY;
    end else if (do_write) begin
      AXI_BVALID_O <= 1'b1;
      AXI_BRESP_O <= (reg_sel(awaddr_ff) == `SVR_SEL_NONE ||
                      reg_sel(awaddr_ff) == `SVR_SEL_STATUS) ?
                     `SVR_RESP_SLVERR : `SVR_RESP_OKAY;
    end else if (AXI_BREADY_I) begin
      AXI_BVALID_O <= 1'b0;
    end
  end

  // Software-written configuration
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ctrl_ff <= `SVR_CTRL_RST;
      int_mask_ff <= `SVR_MASK_RST;
      wd_adj_ff <= `SVR_ADJ_RST;
      rst_adj_ff <= `SVR_ADJ_RST;
    end else if (do_write) begin
      case (reg_sel(awaddr_ff))
        `SVR_SEL_CTRL: ctrl_ff <= wstrb_ff[0] ? wdata_ff[`SVR_CTRL_WIN_BIT]
                                              : ctrl_ff;
        `SVR_SEL_INT_MASK: int_mask_ff <= wstrb_ff[0] ?
                                          wdata_ff[`SVR_EV_W-1:0] :
                                          int_mask_ff;
        `SVR_SEL_WD_ADJ: wd_adj_ff <= merge(wd_adj_ff, wdata_ff, wstrb_ff);
        `SVR_SEL_RST_ADJ: rst_adj_ff <= merge(rst_adj_ff, wdata_ff,
                                              wstrb_ff);
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // Sticky status: a new event wins over a write-one clear
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      int_stat_ff <= '0;
    end else if (do_write && reg_sel(awaddr_ff) == `SVR_SEL_INT_STAT) begin
      int_stat_ff <= (int_stat_ff & ~wmerged[`SVR_EV_W-1:0]) | events;
    end else begin
      int_stat_ff <= int_stat_ff | events;
    end
  end

  // Level interrupt from unmasked sticky bits
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(int_stat_ff & int_mask_ff);
    end
  end

  // Read path: one read at a time, data one cycle after the address
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      AXI_ARREADY_O <= 1'b1;
      AXI_RVALID_O <= 1'b0;
      AXI_RDATA_O <= '0;
      AXI_RRESP_O <= `SVR_RESP_OKAY;
    end else if (AXI_ARVALID_I && AXI_ARREADY_O) begin
      AXI_ARREADY_O <= 1'b0;
      AXI_RVALID_O <= 1'b1;
      AXI_RRESP_O <= `SVR_RESP_OKAY;
      case (reg_sel(AXI_ARADDR_I))
        `SVR_SEL_CTRL: AXI_RDATA_O <= {31'h0, ctrl_ff};
        `SVR_SEL_STATUS: AXI_RDATA_O <= {28'h0, SUPPLY_BELOW_THRESH_I,
                                         wd_en, !POWER_FAIL_FLAG_OUT_N_O,
                                         !RESET_N_O};
        `SVR_SEL_INT_STAT: AXI_RDATA_O <= {29'h0, int_stat_ff};
        `SVR_SEL_INT_MASK: AXI_RDATA_O <= {29'h0, int_mask_ff};
        `SVR_SEL_WD_ADJ: AXI_RDATA_O <= wd_adj_ff;
        `SVR_SEL_RST_ADJ: AXI_RDATA_O <= rst_adj_ff;
        default: begin
          AXI_RDATA_O <= '0;
          AXI_RRESP_O <= `SVR_RESP_SLVERR;
        end
      endcase
    end else if (AXI_RVALID_O && AXI_RREADY_I) begin
      AXI_RVALID_O <= 1'b0;
      AXI_ARREADY_O <= 1'b1;
    end
  end

  // Checks on the supervisor behaviour
  sequence s_stretch_end;
    state_ff == svr_pkg::ST_STRETCH && stretch_done &&
    !SUPPLY_BELOW_THRESH_I;
  endsequence

  sequence s_plain_expiry;
    running && !windowed && wd_en && !kick_edge &&
    ({1'b0, wd_cnt} + 1'b1 >= {1'b0, wd_len});
  endsequence

  a_supply_hold: assert property (
    SUPPLY_BELOW_THRESH_I |=>
    !RESET_N_O [*2])
    else $error("reset released while supply low");
  a_stretch_release: assert property (
    $rose(RESET_N_O) |-> $past(state_ff) == svr_pkg::ST_STRETCH &&
    $past(rst_cnt) + 1'b1 >= $past(rst_len))
    else $error("reset released before the stretch ended");
  a_stretch_done: assert property (
    s_stretch_end |=> RESET_N_O && running)
    else $error("reset not released after stretch");
  a_kick_timeout: assert property (
    s_plain_expiry |=> !RESET_N_O && state_ff == svr_pkg::ST_STRETCH ||
    state_ff == svr_pkg::ST_HOLD)
    else $error("missing kick did not reset");
  a_edge_clears: assert property (
    running && kick_edge && !wd_fault |=> wd_cnt == '0)
    else $error("kick edge did not clear counter");
  a_early_kick: assert property (
    running && windowed && wd_en && kick_edge && wd_cnt < fast_len
    |=> !RESET_N_O)
    else $error("early kick did not reset");
  a_count_idle: assert property (
    !running |=> wd_cnt == '0)
    else $error("watchdog counted during reset");
  a_strap_disable: assert property (
    windowed && wsel == `SVR_WSEL_DIS |-> !wd_en ##1 wd_cnt == '0)
    else $error("disable code left watchdog on");
  a_fixed_wd: assert property (
    WATCHDOG_PERIOD_STRAP_I |-> wd_len == CW'(WD_CYC))
    else $error("fixed watchdog timeout not used");
  a_fixed_rst: assert property (
    RESET_PERIOD_STRAP_I |-> rst_len == CW'(RST_CYC))
    else $error("fixed reset timeout not used");
  a_pf_flag: assert property (
    POWER_FAIL_SENSE_IN_BELOW_I |=> !POWER_FAIL_FLAG_OUT_N_O)
    else $error("power-fail flag not asserted");
  a_pin_disable: assert property (
    !windowed && !WATCHDOG_DISABLE_IN_I && running |=> wd_cnt == '0)
    else $error("disable pin left watchdog counting");

endmodule : supervisor_watchdog_reset
`default_nettype wire

/* File: design/svr_defines.svh */
// Constants for the supervisor: map, fields, reset values, timing
`ifndef SVR_DEFINES_SVH
`define SVR_DEFINES_SVH

// Clock rate and documented times
`define SVR_CLK_HZ 50000000
`define SVR_RST_TIME_MS 200
`define SVR_WD_TIME_MS 400
`define SVR_CYC_PER_MS (`SVR_CLK_HZ / 1000)

// Register byte offsets
`define SVR_OFS_CTRL 6'h00
`define SVR_OFS_STATUS 6'h04
`define SVR_OFS_INT_STAT 6'h08
`define SVR_OFS_INT_MASK 6'h0c
`define SVR_OFS_WD_ADJ 6'h10
`define SVR_OFS_RST_ADJ 6'h14

// Register select codes
`define SVR_SEL_CTRL 3'h0
`define SVR_SEL_STATUS 3'h1
`define SVR_SEL_INT_STAT 3'h2
`define SVR_SEL_INT_MASK 3'h3
`define SVR_SEL_WD_ADJ 3'h4
`define SVR_SEL_RST_ADJ 3'h5
`define SVR_SEL_NONE 3'h7

// Field positions
`define SVR_CTRL_WIN_BIT 0
`define SVR_EV_WD_BIT 0
`define SVR_EV_SUPPLY_BIT 1
`define SVR_EV_PF_BIT 2
`define SVR_EV_W 3

// Reset values
`define SVR_CTRL_RST 1'h0
`define SVR_MASK_RST 3'h0
`define SVR_ADJ_RST 32'h000f4240

// Window select codes and ratio shifts (8, 16, 64)
`define SVR_WSEL_DIS 2'h1
`define SVR_WSEL_R8 2'h0
`define SVR_WSEL_R16 2'h2
`define SVR_SHIFT_R8 3'h3
`define SVR_SHIFT_R16 3'h4
`define SVR_SHIFT_R64 3'h6

// AXI responses
`define SVR_RESP_OKAY 2'h0
`define SVR_RESP_SLVERR 2'h2

`endif

/* File: design/svr_pkg.sv */
// Types shared by the supervisor design files
`default_nettype none
package svr_pkg;

  // Reset generator states, one-hot
  typedef enum logic [2:0] {
    ST_HOLD = 3'h1,
    ST_STRETCH = 3'h2,
    ST_RUN = 3'h4
  } rst_state_t;

endpackage : svr_pkg
`default_nettype wire

/* File: design/svr_interval_timer.sv */
// Saturating interval counter with synchronous clear
`timescale 1ns/10ps
`default_nettype none

module svr_interval_timer #(
  parameter int unsigned CW = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clear_i,
  // Count
  output logic [CW-1:0] count_o
);

  // Narrow counters could not hold the timeouts
  generate
    if (CW < 8) begin : g_bad_width
      $error("svr_interval_timer: CW below 8");
    end
  endgenerate

  // Counts up, holds at all-ones so a long stall never wraps to zero
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_o <= '0;
    end else if (clear_i) begin
      count_o <= '0;
    end else if (count_o != {CW{1'b1}}) begin
      count_o <= count_o + 1'b1;
    end
  end

endmodule : svr_interval_timer
`default_nettype wire

/* File: verif/svr_kick_model.sv */
// Processor model that toggles the watchdog kick pin
`timescale 1ns/10ps
`default_nettype none

module svr_kick_model (
  // Clock
  input wire logic clk_i,
  // Kick control
  input wire logic run_i,
  input wire logic [15:0] gap_i,
  // Kick pin
  output logic kick_o
);
  logic [15:0] gap_cnt_ff; // Cycles since last toggle

  initial kick_o = 1'b0;
  initial gap_cnt_ff = 16'h0000;

  always @(posedge clk_i) begin
    if (!run_i) begin
      gap_cnt_ff <= 16'h0000; // Pin parks while stopped
    end else if (gap_cnt_ff + 16'h0001 >= gap_i) begin
      gap_cnt_ff <= 16'h0000;
      kick_o <= ~kick_o; // Either edge is a kick
    end else begin
      gap_cnt_ff <= gap_cnt_ff + 16'h0001;
    end
  end
endmodule : svr_kick_model

`default_nettype wire

/* File: verif/tb_supervisor_watchdog_reset.sv */
// Self-checking bench for the supervisor with a kick model
`timescale 1ns/10ps
`default_nettype none
`include "svr_defines.svh"

module tb_supervisor_watchdog_reset;
  localparam int RST = 20; // Short reset timeout
  localparam int WD = 256; // Short watchdog timeout
  // Pins
  logic clk, rst_n, sup, pf, ws0, ws1, dis, wd_strap, rst_strap, kick, run;
  logic rst_out_n, flag_n, irq;
  logic [15:0] gap;
  // Register bus
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  // Window cases: straps, kick gap (0 = none), fault expected
  logic [1:0] wsel [6] = '{2'h0, 2'h0, 2'h2, 2'h3, 2'h0, 2'h1};
  int gaps [6] = '{64, 20, 20, 20, 300, 0};
  logic fault [6] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0; // Hang guard
  int n;

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  supervisor_watchdog_reset #(.RST_CYC(RST), .WD_CYC(WD)) dut (
    .CLK_I(clk), .RST_N_I(rst_n), .SUPPLY_BELOW_THRESH_I(sup),
    .POWER_FAIL_SENSE_IN_BELOW_I(pf), .WATCHDOG_KICK_INPUT_I(kick),
    .WINDOW_SELECT_BIT0_I(ws0), .WINDOW_SELECT_BIT1_I(ws1),
    .WATCHDOG_DISABLE_IN_I(dis), .WATCHDOG_PERIOD_STRAP_I(wd_strap),
    .RESET_PERIOD_STRAP_I(rst_strap), .RESET_N_O(rst_out_n),
    .POWER_FAIL_FLAG_OUT_N_O(flag_n), .IRQ_O(irq),
    .AXI_AWADDR_I(awaddr), .AXI_AWVALID_I(awvalid),
    .AXI_AWREADY_O(awready), .AXI_WDATA_I(wdata), .AXI_WSTRB_I(wstrb),
    .AXI_WVALID_I(wvalid), .AXI_WREADY_O(wready), .AXI_BRESP_O(bresp),
    .AXI_BVALID_O(bvalid), .AXI_BREADY_I(bready), .AXI_ARADDR_I(araddr),
    .AXI_ARVALID_I(arvalid), .AXI_ARREADY_O(arready),
    .AXI_RDATA_O(rdata), .AXI_RRESP_O(rresp), .AXI_RVALID_O(rvalid),
    .AXI_RREADY_I(rready));

  svr_kick_model kicker (.clk_i(clk), .run_i(run), .gap_i(gap),
    .kick_o(kick));

  // Verdict and end of run
  task automatic finish_test();
    if (err_total == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : finish_test

  // Value compare
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // Cycle count compare against a window
  task automatic chk_rng(input string nm, input int lo, input int hi,
                         input int g);
    tests_run++;
    if (g < lo || g > hi) begin
      err_total++;
      $display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask : chk_rng

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  // Edges until reset output shows v; bounded
  task automatic until_out(input logic v, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (rst_out_n !== v && c < 2000);
  endtask : until_out

  // Count reset-low samples over k cycles
  task automatic lows(input int k, output int c);
    c = 0;
    repeat (k) begin
      @(posedge clk);
      if (rst_out_n !== 1'b1) c++;
    end
  endtask : lows

  // Write: offer both channels, release each when taken, then response
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1; // Raised late so it never toggles twice in a step
    do @(posedge clk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  // Read: address, then data with response
  task automatic axi_rd(input logic [5:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge clk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Supply dip; straps only change while reset is held
  task automatic dip(input int len, input logic [1:0] ws);
    sup <= 1'b1;
    tick(5);
    chk("reset in low supply", 32'h0, rst_out_n);
    ws0 <= ws[0];
    ws1 <= ws[1];
    tick(1);
    sup <= 1'b0;
    until_out(1'b1, n);
    chk_rng("reset stretch", len, len + 4, n);
  endtask : dip

  // Unkicked watchdog fault, then its reset pulse
  task automatic wd_cycle(input int lim, input int rlen);
    until_out(1'b0, n);
    chk_rng("time to watchdog reset", lim - 2, lim + 3, n);
    until_out(1'b1, n);
    chk_rng("watchdog reset length", rlen, rlen + 4, n);
  endtask : wd_cycle

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      finish_test();
    end
  end

  initial begin
    rst_n = 1'b0; sup = 1'b0; pf = 1'b0; ws0 = 1'b0; ws1 = 1'b0;
    dis = 1'b1; wd_strap = 1'b1; rst_strap = 1'b1; run = 1'b1;
    gap = 16'h0064; awaddr = 6'h00; araddr = 6'h00; wdata = 32'h0;
    wstrb = 4'hf; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0;
    tick(2);
    rst_n <= 1'b1;
    until_out(1'b1, n);
    chk_rng("power-up stretch", RST, RST + 4, n);
    // Register defaults and refusals
    axi_rd(`SVR_OFS_CTRL);
    chk("ctrl default", 32'h0, rd);
    axi_rd(`SVR_OFS_INT_MASK);
    chk("mask default", 32'h0, rd);
    axi_rd(`SVR_OFS_WD_ADJ);
    chk("wd adjust default", `SVR_ADJ_RST, rd);
    axi_rd(`SVR_OFS_RST_ADJ);
    chk("reset adjust default", `SVR_ADJ_RST, rd);
    axi_rd(`SVR_OFS_STATUS);
    chk("status idle", 32'h4, rd);
    axi_rd(6'h18);
    chk("unmapped read resp", `SVR_RESP_SLVERR, resp);
    axi_wr(`SVR_OFS_STATUS, 32'hffffffff);
    chk("status write resp", `SVR_RESP_SLVERR, resp);
    // Supply event interrupt, power-fail flag masked
    axi_wr(`SVR_OFS_INT_MASK, 32'h2);
    dip(RST, 2'h0);
    tick(2);
    chk("irq on supply event", 32'h1, irq);
    axi_rd(`SVR_OFS_INT_STAT);
    chk("supply event bit", 32'h1, rd[1]);
    axi_wr(`SVR_OFS_INT_STAT, 32'h2);
    tick(2);
    chk("irq after clear", 32'h0, irq);
    pf <= 1'b1;
    tick(3);
    chk("power-fail flag", 32'h0, flag_n);
    chk("masked irq", 32'h0, irq);
    pf <= 1'b0;
    tick(3);
    chk("power-fail flag release", 32'h1, flag_n);
    // Plain watchdog
    lows(3 * WD, n);
    chk("reset with kicks", 32'h0, n);
    run <= 1'b0;
    dip(RST, 2'h0);
    wd_cycle(WD, RST);
    wd_cycle(WD, RST);
    axi_rd(`SVR_OFS_INT_STAT);
    chk("watchdog event bit", 32'h1, rd[0]);
    dis <= 1'b0;
    lows(3 * WD, n);
    chk("reset while disabled", 32'h0, n);
    run <= 1'b1;
    dis <= 1'b1;
    // Adjusted timeouts from registers
    wd_strap <= 1'b0;
    rst_strap <= 1'b0;
    axi_wr(`SVR_OFS_WD_ADJ, 32'h000000a0);
    axi_wr(`SVR_OFS_RST_ADJ, 32'h00000028);
    run <= 1'b0;
    dip(40, 2'h0);
    wd_cycle(160, 40);
    wd_strap <= 1'b1;
    rst_strap <= 1'b1;
    // Windowed watchdog over ratios, early, late and disable
    run <= 1'b1;
    axi_wr(`SVR_OFS_CTRL, 32'h1);
    axi_rd(`SVR_OFS_CTRL);
    chk("ctrl windowed", 32'h1, rd);
    for (int i = 0; i < 6; i++) begin
      run <= 1'b0;
      dip(RST, wsel[i]);
      gap <= gaps[i][15:0];
      run <= (gaps[i] != 0);
      lows(400, n);
      chk("window fault", fault[i], n != 0);
    end
    finish_test();
  end
endmodule : tb_supervisor_watchdog_reset

`default_nettype wire
